// ---- pkg/fault_prot_cfg.svh ----
// constants for the per-channel switch fault protection block
// assumes a 20 MHz control clock and an apb register port
`ifndef FAULT_PROT_CFG_SVH
`define FAULT_PROT_CFG_SVH

// ********************************************************
// register byte offsets
// ********************************************************
`define REG_GLOBAL_SETUP 12'h000
`define REG_SUPPLY_STATUS 12'h004
`define REG_CH0_SETUP 12'h008
`define REG_CH1_SETUP 12'h00C
`define REG_CH0_FAULT 12'h010
`define REG_CH1_FAULT 12'h014
`define REG_DELATCH 12'h018

// ********************************************************
// field positions
// ********************************************************
`define GSR_GUARD_OFF_BIT 0
`define SSR_HIGH_BIT 0
`define SSR_LOW_BIT 1
`define CSR_SOURCE_BIT 0
`define CSR_PROFILE_BIT 1
`define CSR_RETRY_EN_BIT 2
`define CSR_SWITCH_MODE_BIT 3
`define CSR_RETRIES_LSB 4
`define CSR_WIN1_LSB 8
`define CSR_WIN2_LSB 16
`define FLT_OC_BIT 0
`define FLT_SC_BIT 1
`define FLT_PROFILE_BIT 2
`define FLT_ON_BIT 3
`define FLT_SENSE_BIT 4

// ********************************************************
// reset values and timing
// ********************************************************
`define CH_SETUP_RESET 32'h00FF_FF40
`define FAULT_REACT_NS 1000
`define CLK_PERIOD_NS 50
`define FAULT_REACT_CYC ((`FAULT_REACT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pkg/fault_prot_pkg.sv ----
// types for the switch fault protection block
// assumes nothing beyond the constant header
`default_nettype none
package fault_prot_pkg;
  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_ON = 4'b0010,
    CH_TRIP = 4'b0100,
    CH_LATCHED = 4'b1000
  } ch_state_t;
endpackage
`default_nettype wire

// ---- hw/switch_fault_protection.sv ----
// dual-channel overcurrent, short-circuit and supply fault protection
// assumes comparator inputs are asynchronous and an apb master on mclk_in
`timescale 1ns/1ps
`default_nettype none
`include "fault_prot_cfg.svh"
module switch_fault_protection #(
  parameter int REACT_CYC = `FAULT_REACT_CYC
) (
  // clock and control
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // channel commands and comparators
  input wire logic [1:0] on_cmd_in,
  input wire logic [1:0] profile_select_pin_in,
  input wire logic [1:0] above_upper_in,
  input wire logic [1:0] above_middle_in,
  input wire logic [1:0] above_lower_in,
  input wire logic [1:0] short_in,
  input wire logic supply_high_in,
  input wire logic supply_ok_hys_in,
  input wire logic supply_low_in,
  // outputs
  output logic [1:0] switch_on_out,
  output logic fault_out_n,
  output logic sense_valid_strobe_pin
);
  localparam int NIN = 13;
  localparam logic [7:0] REACT = 8'(REACT_CYC);
  // ********************************************************
  // input synchronisers
  // ********************************************************
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_r, s2_r, s3_r, flt_r;
  assign raw_in = {profile_select_pin_in, above_upper_in, above_middle_in, above_lower_in,
                   short_in, supply_high_in, supply_ok_hys_in, supply_low_in};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          flt_r[gi] <= 1'b0;
        end else if (clk_en_in) begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            flt_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  logic [1:0] pin_sel, oc_hi, oc_mid, oc_lo, sc_det;
  logic ov_det, ov_clear, uv_det;
  assign {pin_sel, oc_hi, oc_mid, oc_lo, sc_det, ov_det, ov_clear, uv_det} = flt_r;

  // ********************************************************
  // registers
  // ********************************************************
  logic guard_off_r;
  logic supply_high_flag_r, supply_low_flag_r;
  logic [31:0] setup_r [2];
  logic [1:0] overcurrent_flag_r, short_circuit_flag_r;
  logic [1:0] delatch_r;
  logic wr_en, rd_en;
  logic ov_active, uv_prev_r;
  logic [1:0] any_turn_on;
  // writes and read side effects land only on the completion edge, where pready is seen high,
  // so a held access phase never writes twice or clears a flag early
  assign wr_en = psel_in && penable_in && pwrite_in && pready_out;
  assign rd_en = psel_in && penable_in && !pwrite_in && pready_out;
  assign ov_active = ov_det && !guard_off_r;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      guard_off_r <= 1'b0;
      setup_r[0] <= `CH_SETUP_RESET;
      setup_r[1] <= `CH_SETUP_RESET;
      delatch_r <= 2'h0;
    end else if (clk_en_in) begin
      delatch_r <= 2'h0;
      if (wr_en) begin
        unique case (paddr_in)
          `REG_GLOBAL_SETUP: guard_off_r <= pwdata_in[`GSR_GUARD_OFF_BIT];
          `REG_CH0_SETUP: setup_r[0] <= pwdata_in;
          `REG_CH1_SETUP: setup_r[1] <= pwdata_in;
          `REG_DELATCH: delatch_r <= pwdata_in[1:0];
          default: ;
        endcase
      end
    end
  end

  // supply flags: set wins over the read clear
  logic ov_gone_r;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      supply_high_flag_r <= 1'b0;
      supply_low_flag_r <= 1'b0;
      ov_gone_r <= 1'b1;
      uv_prev_r <= 1'b0;
    end else if (clk_en_in) begin
      uv_prev_r <= uv_det;
      if (ov_det) begin
        ov_gone_r <= 1'b0;
      end else if (ov_clear) begin
        ov_gone_r <= 1'b1;
      end
      if (ov_det) begin
        supply_high_flag_r <= 1'b1;
      end else if (rd_en && paddr_in == `REG_SUPPLY_STATUS && ov_gone_r) begin
        supply_high_flag_r <= 1'b0;
      end
      if (uv_det) begin
        supply_low_flag_r <= 1'b1;
      end else if (|any_turn_on ||
                   (rd_en && paddr_in == `REG_SUPPLY_STATUS && |on_cmd_in)) begin
        supply_low_flag_r <= 1'b0;
      end
    end
  end

  // ********************************************************
  // per-channel protection
  // ********************************************************
  fault_prot_pkg::ch_state_t st_r [2];
  logic [1:0] profile_type, sw_on, blank, uv_hold_r, ov_hold;
  logic [1:0] chan_fault;
  logic [23:0] dur_r [2];
  logic [7:0] react_r [2];
  logic [3:0] retry_r [2];
  logic [1:0] seg_r [2];
  logic [1:0] clean_r, was_on_r, prof_done_r;
  assign ov_hold = {2{ov_active || !ov_gone_r && !guard_off_r}};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic [31:0] cs;
      logic sw_mode, retry_en, turn_on, turn_off, trip, oc_now, want_on;
      logic [23:0] width;
      assign cs = setup_r[gi];
      // source bit 0 follows the pin, 1 the written setting
      assign profile_type[gi] = cs[`CSR_SOURCE_BIT] ? cs[`CSR_PROFILE_BIT] : pin_sel[gi];
      assign sw_mode = cs[`CSR_SWITCH_MODE_BIT];
      assign retry_en = cs[`CSR_RETRY_EN_BIT];
      assign want_on = on_cmd_in[gi] && !uv_det && !ov_hold[gi] && !uv_hold_r[gi];
      assign turn_on = want_on && st_r[gi] == fault_prot_pkg::CH_OFF;
      assign turn_off = st_r[gi] == fault_prot_pkg::CH_ON && !on_cmd_in[gi];
      assign any_turn_on[gi] = turn_on;
      // motor has a single window and always uses the first width field
      assign width = {16'h0000, (profile_type[gi] || seg_r[gi] == 2'd1) ? cs[`CSR_WIN1_LSB +: 8]
                                                                        : cs[`CSR_WIN2_LSB +: 8]};
      // lighting uses a time-driven stair, motor opens above the upper limit at once and above the lower limit once past its window
      always_comb begin
        if (profile_type[gi]) begin
          oc_now = oc_hi[gi] || (oc_lo[gi] && dur_r[gi] > width);
          blank[gi] = oc_lo[gi];
        end else begin
          unique case (seg_r[gi])
            2'd1: oc_now = oc_hi[gi] || dur_r[gi] > width;
            2'd2: oc_now = oc_mid[gi] || dur_r[gi] > width;
            default: oc_now = oc_lo[gi];
          endcase
          blank[gi] = seg_r[gi] != 2'd0;
        end
      end
      assign trip = st_r[gi] == fault_prot_pkg::CH_ON && oc_now;
      assign sw_on[gi] = st_r[gi] == fault_prot_pkg::CH_ON || st_r[gi] == fault_prot_pkg::CH_TRIP;
      assign chan_fault[gi] = overcurrent_flag_r[gi] || short_circuit_flag_r[gi];

      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          st_r[gi] <= fault_prot_pkg::CH_OFF;
          dur_r[gi] <= 24'h000000;
          react_r[gi] <= 8'h00;
          retry_r[gi] <= 4'h0;
          seg_r[gi] <= 2'd0;
          clean_r[gi] <= 1'b1;
          was_on_r[gi] <= 1'b0;
          prof_done_r[gi] <= 1'b0;
          uv_hold_r[gi] <= 1'b0;
          overcurrent_flag_r[gi] <= 1'b0;
          short_circuit_flag_r[gi] <= 1'b0;
        end else if (clk_en_in) begin
          // leaving undervoltage with command on waits for a delatch
          if (uv_det && on_cmd_in[gi]) begin
            uv_hold_r[gi] <= 1'b1;
          end else if (delatch_r[gi]) begin
            uv_hold_r[gi] <= 1'b0;
          end
          // count only while switched on and inside a window
          if (delatch_r[gi]) begin
            dur_r[gi] <= 24'h000000;
          end else if (st_r[gi] == fault_prot_pkg::CH_ON && blank[gi]) begin
            dur_r[gi] <= dur_r[gi] + 24'h000001;
          end else if (turn_off && profile_type[gi] && clean_r[gi] && !sw_mode) begin
            dur_r[gi] <= 24'h000000;
          end
          if (turn_on) begin
            clean_r[gi] <= 1'b1;
          end else if (oc_lo[gi]) begin
            clean_r[gi] <= 1'b0;
          end
          if (!profile_type[gi] && st_r[gi] == fault_prot_pkg::CH_ON &&
              seg_r[gi] != 2'd0 && dur_r[gi] >= width && !oc_now) begin
            seg_r[gi] <= seg_r[gi] + 2'd1 == 2'd3 ? 2'd0 : seg_r[gi] + 2'd1;
            dur_r[gi] <= 24'h000000;
          end
          // lighting restarts each turn-on, switch mode only the first
          if (turn_on && !profile_type[gi] && !(sw_mode && prof_done_r[gi])) begin
            seg_r[gi] <= 2'd1;
            dur_r[gi] <= 24'h000000;
            prof_done_r[gi] <= 1'b1;
          end
          if (delatch_r[gi]) begin
            prof_done_r[gi] <= 1'b0;
            retry_r[gi] <= 4'h0;
            overcurrent_flag_r[gi] <= 1'b0;
            short_circuit_flag_r[gi] <= 1'b0;
          end
          was_on_r[gi] <= sw_on[gi];
          unique case (st_r[gi])
            fault_prot_pkg::CH_OFF: begin
              if (turn_on) begin
                st_r[gi] <= fault_prot_pkg::CH_ON;
              end
            end
            fault_prot_pkg::CH_ON: begin
              if (sc_det[gi] && !was_on_r[gi] || uv_det || ov_active) begin
                st_r[gi] <= fault_prot_pkg::CH_LATCHED;
                short_circuit_flag_r[gi] <= sc_det[gi] && !was_on_r[gi];
              end else if (trip) begin
                st_r[gi] <= fault_prot_pkg::CH_TRIP;
                react_r[gi] <= REACT;
              end else if (!on_cmd_in[gi]) begin
                st_r[gi] <= fault_prot_pkg::CH_OFF;
              end
            end
            fault_prot_pkg::CH_TRIP: begin
              if (react_r[gi] <= 8'h01) begin
                st_r[gi] <= fault_prot_pkg::CH_LATCHED;
                overcurrent_flag_r[gi] <= 1'b1;
              end else begin
                react_r[gi] <= react_r[gi] - 8'h01;
              end
            end
            fault_prot_pkg::CH_LATCHED: begin
              if (delatch_r[gi]) begin
                st_r[gi] <= fault_prot_pkg::CH_OFF;
              end else if (retry_en && retry_r[gi] < cs[`CSR_RETRIES_LSB +: 4] &&
                           !uv_det && !ov_hold[gi] && chan_fault[gi]) begin
                st_r[gi] <= fault_prot_pkg::CH_OFF;
                retry_r[gi] <= retry_r[gi] + 4'h1;
                if (!profile_type[gi]) begin
                  dur_r[gi] <= 24'h000000;
                end
              end else if (!chan_fault[gi] && !uv_det && !ov_hold[gi]) begin
                st_r[gi] <= fault_prot_pkg::CH_OFF;
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // ********************************************************
  // outputs and read path
  // ********************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_in)
      `REG_GLOBAL_SETUP: rd_mux[`GSR_GUARD_OFF_BIT] = guard_off_r;
      `REG_SUPPLY_STATUS: rd_mux[1:0] = {supply_low_flag_r, supply_high_flag_r};
      `REG_CH0_SETUP: rd_mux = setup_r[0];
      `REG_CH1_SETUP: rd_mux = setup_r[1];
      `REG_CH0_FAULT: rd_mux[4:0] = {blank[0], sw_on[0], profile_type[0],
                                     short_circuit_flag_r[0], overcurrent_flag_r[0]};
      `REG_CH1_FAULT: rd_mux[4:0] = {blank[1], sw_on[1], profile_type[1],
                                     short_circuit_flag_r[1], overcurrent_flag_r[1]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      switch_on_out <= 2'h0;
      fault_out_n <= 1'b1;
      sense_valid_strobe_pin <= 1'b1;
    end else if (clk_en_in) begin
      // one wait state: ready rises in the second access cycle, then drops
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && paddr_in > `REG_DELATCH;
      prdata_out <= rd_mux;
      switch_on_out <= sw_on;
      // fault low on any latched channel fault, undervoltage, the cycle after undervoltage while a hold is set, or overvoltage while the guard is on
      fault_out_n <= !(|chan_fault || uv_det || ov_active || (uv_prev_r && |uv_hold_r));
      sense_valid_strobe_pin <= !(|(blank & sw_on));
    end
  end
endmodule // switch_fault_protection
`default_nettype wire

// ---- test/fault_prot_asserts.sv ----
// port checker for the switch fault protection block
// assumes an apb master that holds each request until pready
`timescale 1ns/1ps
`default_nettype none
module fault_prot_asserts (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // channels and supply
  input wire logic [1:0] on_cmd_in,
  input wire logic [1:0] short_in,
  input wire logic supply_low_in,
  input wire logic [1:0] switch_on_out,
  input wire logic fault_out_n,
  input wire logic sense_valid_strobe_pin
);
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  ready_wait_a: assert property (psel_in && penable_in && !$past(penable_in) |=> pready_out)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  err_range_a: assert property (pready_out && psel_in && paddr_in > 12'h018 |-> pslverr_out)
    else $error("unmapped access without pslverr");
  low_supply_off_a: assert property (supply_low_in [*7] |-> switch_on_out == 2'b00 && !fault_out_n)
    else $error("undervoltage left a channel on");
  trip_fault_a: assert property ($fell(switch_on_out[0]) && on_cmd_in[0] && $past(on_cmd_in[0])
    |-> ##[0:2] !fault_out_n)
    else $error("commanded channel dropped without fault");
  sense_idle_a: assert property ((switch_on_out == 2'b00) [*2] |-> sense_valid_strobe_pin)
    else $error("sense blanked with both channels off");
  on_cmd_a: assert property ($rose(switch_on_out[0]) |-> $past(on_cmd_in[0]))
    else $error("channel on without command");
  short_off_a: assert property ($rose(switch_on_out[0]) && short_in[0] && $past(short_in[0], 6)
    |-> ##[1:2] !switch_on_out[0])
    else $error("short at turn-on not cut off");
  cover property ($fell(fault_out_n));
  cover property (pready_out && pslverr_out);
  cover property ($rose(switch_on_out[0]) ##[1:2] !switch_on_out[0]);
endmodule // fault_prot_asserts
bind switch_fault_protection fault_prot_asserts i_fault_prot_asserts (.mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .on_cmd_in(on_cmd_in),
  .short_in(short_in), .supply_low_in(supply_low_in), .switch_on_out(switch_on_out),
  .fault_out_n(fault_out_n), .sense_valid_strobe_pin(sense_valid_strobe_pin));
`default_nettype wire

// ---- test/load_model.sv ----
// load and comparator model behind the two switches
// assumes levels 0 none, 1 above lower, 2 above middle, 3 above upper
`timescale 1ns/1ps
`default_nettype none
module load_model (
  // drive and load setting
  input wire logic [1:0] switch_on_in,
  input wire logic [3:0] level_in,
  input wire logic [1:0] shorted_in,
  // comparators
  output logic [1:0] above_upper_out,
  output logic [1:0] above_middle_out,
  output logic [1:0] above_lower_out,
  output logic [1:0] short_out
);
  // ********************************
  // comparators
  // ********************************
  // current stops when the switch opens, so none of the three level comparators stays high then
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      above_lower_out[c] = switch_on_in[c] && level_in[2*c+:2] >= 2'h1;
      above_middle_out[c] = switch_on_in[c] && level_in[2*c+:2] >= 2'h2;
      above_upper_out[c] = switch_on_in[c] && level_in[2*c+:2] == 2'h3;
    end
  end
  // a hard short is seen ahead of turn-on so it clears the input filter
  assign short_out = shorted_in;
endmodule // load_model
`default_nettype wire

// ---- test/switch_fault_protection_tb.sv ----
// self-checking bench for the switch fault protection block
// assumes the load model on the comparators and apb from the bench
`timescale 1ns/1ps
`default_nettype none
`include "fault_prot_cfg.svh"
module switch_fault_protection_tb;
  logic mclk_in, rst, psel, pen, pwr, sh, hys, sl, fault_n, sense, pready, perr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] on_cmd, pin, shorted, sw, au, am, al, sc;
  logic [3:0] lvl;
  int failures = 0;
  int checked = 0;
  switch_fault_protection #(.REACT_CYC(2)) i_switch_fault_protection (.mclk_in(mclk_in),
    .sys_rst_in(rst), .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .on_cmd_in(on_cmd), .profile_select_pin_in(pin),
    .above_upper_in(au), .above_middle_in(am), .above_lower_in(al), .short_in(sc),
    .supply_high_in(sh), .supply_ok_hys_in(hys), .supply_low_in(sl), .switch_on_out(sw),
    .fault_out_n(fault_n), .sense_valid_strobe_pin(sense));
  load_model i_load_model (.switch_on_in(sw), .level_in(lvl), .shorted_in(shorted),
    .above_upper_out(au), .above_middle_out(am), .above_lower_out(al), .short_out(sc));
  // ********************************
  // helpers
  // ********************************
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // release a cycle after the answer so the next setup never lands on the same edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    do begin @(posedge mclk_in); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = perr;
    psel <= 1'b0; pen <= 1'b0;
    if (n >= 20) begin failures++; finish_test(); end
    @(posedge mclk_in);
  endtask
  task rd(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask
  task wait_sw(input logic [1:0] v, output int n);
    n = 0;
    while (sw !== v && n < 60) begin @(posedge mclk_in); n++; end
    if (n >= 60) begin failures++; finish_test(); end
  endtask
  // ********************************
  // scenarios
  // ********************************
  task t_regs();
    rd(`REG_CH0_SETUP); chk(q, `CH_SETUP_RESET);
    rd(`REG_SUPPLY_STATUS); chk(q, 32'h0000_0000);
    apb(1'b1, `REG_SUPPLY_STATUS, 32'h0000_0003); rd(`REG_SUPPLY_STATUS); chk(q, 32'h0);
    rd(12'h01C); chk(e, 1'b1);
  endtask
  task t_profile();
    pin <= 2'h1; tick(8); rd(`REG_CH0_FAULT); chk(q[2], 1'b1);
    pin <= 2'h0; tick(8); rd(`REG_CH0_FAULT); chk(q[2], 1'b0);
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A03); rd(`REG_CH0_FAULT); chk(q[2], 1'b1);
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A00);
  endtask
  task clear_ch();
    on_cmd <= 2'h0; lvl <= 4'h0; shorted <= 2'h0;
    apb(1'b1, `REG_DELATCH, 32'h0000_0003);
  endtask
  task t_upper();
    int n;
    lvl <= 4'h3; on_cmd <= 2'h1; wait_sw(2'h1, n); wait_sw(2'h0, n);
    tick(2); chk(fault_n, 1'b0);
    rd(`REG_CH0_FAULT); chk(q[0], 1'b1);
    clear_ch(); rd(`REG_CH0_FAULT); chk(q[0], 1'b0);
  endtask
  task t_overrun();
    int n;
    lvl <= 4'h2; on_cmd <= 2'h1; wait_sw(2'h1, n); wait_sw(2'h0, n);
    chk(n >= 10, 1'b1);
    chk(n <= 30, 1'b1);
    clear_ch();
  endtask
  task t_clean();
    int n;
    on_cmd <= 2'h1; wait_sw(2'h1, n); tick(2); chk(sense, 1'b0);
    tick(40); chk(sw, 2'h1); chk(sense, 1'b1);
    rd(`REG_CH0_FAULT); chk(q[0], 1'b0);
    clear_ch();
  endtask
  task t_motor();
    int n;
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A03);
    lvl <= 4'h1; on_cmd <= 2'h1; wait_sw(2'h1, n); tick(6);
    chk(sense, 1'b0);
    wait_sw(2'h0, n);
    chk(n + 6 >= 12, 1'b1);
    chk(n + 6 <= 30, 1'b1);
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A00);
    clear_ch();
  endtask
  task t_retry();
    int n;
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A14);
    lvl <= 4'h3; on_cmd <= 2'h1; wait_sw(2'h1, n); wait_sw(2'h0, n);
    wait_sw(2'h1, n); chk(fault_n, 1'b0);
    wait_sw(2'h0, n); tick(20); chk(sw, 2'h0);
    rd(`REG_CH0_FAULT); chk(q[0], 1'b1);
    apb(1'b1, `REG_CH0_SETUP, 32'h0004_0A00);
    clear_ch();
  endtask
  task t_supply();
    int n;
    on_cmd <= 2'h3; wait_sw(2'h3, n); sh <= 1'b1; hys <= 1'b0; tick(8);
    chk(sw, 2'h0); chk(fault_n, 1'b0);
    sh <= 1'b0; tick(8); chk(sw, 2'h0);
    hys <= 1'b1; tick(8); rd(`REG_SUPPLY_STATUS); chk(q[0], 1'b1);
    rd(`REG_SUPPLY_STATUS); chk(q[0], 1'b0);
    clear_ch(); apb(1'b1, `REG_GLOBAL_SETUP, 32'h0000_0001);
    on_cmd <= 2'h1; wait_sw(2'h1, n); sh <= 1'b1; hys <= 1'b0; tick(8);
    chk(sw, 2'h1); chk(fault_n, 1'b1);
    rd(`REG_SUPPLY_STATUS); chk(q[0], 1'b1);
    sh <= 1'b0; hys <= 1'b1; tick(8); apb(1'b1, `REG_GLOBAL_SETUP, 32'h0);
    rd(`REG_SUPPLY_STATUS); chk(q[0], 1'b1);
    sl <= 1'b1; tick(8); chk(sw, 2'h0); chk(fault_n, 1'b0);
    rd(`REG_SUPPLY_STATUS); chk(q[1], 1'b1);
    on_cmd <= 2'h0; sl <= 1'b0; tick(8); chk(fault_n, 1'b1);
    rd(`REG_SUPPLY_STATUS); chk(q[1], 1'b1);
    clear_ch();
  endtask
  task t_short();
    shorted <= 2'h1; tick(8); on_cmd <= 2'h1; tick(12);
    chk(sw, 2'h0); chk(fault_n, 1'b0);
    rd(`REG_CH0_FAULT); chk(q[1], 1'b1);
    clear_ch();
  endtask
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    on_cmd = 2'h0; pin = 2'h0; shorted = 2'h0; lvl = 4'h0; sh = 1'b0; hys = 1'b1; sl = 1'b0;
    tick(3);
    rst <= 1'b0;
    tick(6);
    t_regs(); t_profile(); t_upper(); t_overrun(); t_clean(); t_motor(); t_retry();
    t_supply(); t_short();
    finish_test();
  end
endmodule // switch_fault_protection_tb
`default_nettype wire
